// [rtl/ccd_decoder.sv]
// cache memory command decoder and background sequencer
// Operation
// - opcode 010100 with bits 25-14 zero loads bits 13-0 as the refresh rate.
// - opcode 000000 enables and 000001 disables caching when other bits are zero.
// - opcode 000010 begins and 000011 ends the lock region when other bits are zero.
// - opcodes 010000 and 010001 start a fill, the latter locking, with length and stall.
// - opcodes 000100 and 000101 start copyback and invalidate with length and stall.
// - opcode 000111 sets bus cacheability with bit 14 and bits 13-0 zero.
// - bit 21 gives the instruction bus setting, 0 none and 1 read caching.
// - bits 20-19, 18-17, 16-15 give S, J, K bus caching as none, read, write, both.
// - a start address is bits 16-3 of the address/index word.
// - a start index is bits 16-10 of the address/index word.
// - long commands yield to core accesses and alternate with fetch.
// - a register write during a non-stall long command is aborted and flagged.
// - a running flag stays high while a command sequence is in progress.
// - a block read right after a cache register write stalls four cycles.
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_decoder
  import ccd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        cmd_wr_in,
  input  wire logic        air_wr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        stat_rd_in,
  input  wire logic        blk_rd_in,
  input  wire logic        core_req_in,
  input  wire logic        fetch_req_in,
  input  wire logic        step_ack_in,
  output logic [31:0]      cmd_word_out,
  output logic [31:0]      air_word_out,
  output logic [31:0]      status_out,
  output ccd_cfg_type      cfg_out,
  output ccd_step_type     step_out,
  output logic             step_req_out,
  output logic             fetch_grant_out,
  output logic             core_stall_out,
  output logic             rd_stall_out
);
  typedef struct packed {
    ccd_state_type state;
    logic [31:0]   cmd;
    logic [31:0]   air;
    ccd_cfg_type   cfg;
    logic [8:0]    remain;
    logic          stall_mode;
    logic          aborted;
    logic          turn;
    logic          step_req;
    logic          fetch_grant;
    logic          core_stall;
    logic [2:0]    rd_cnt;
    logic          wr_last;
    logic          load;
    ccd_step_type  step;
  } ccd_regs_type;

  ccd_regs_type r_r;
  ccd_regs_type r_nxt;
  ccd_step_type step_q;

  function automatic logic rest_zero(input logic [31:0] w, input logic [4:0] hi);
    logic [31:0] m;
    m = (32'h1 << (hi + 5'h1)) - 32'h1;
    rest_zero = ((w & m) == 32'h0);
  endfunction

  logic [5:0] op;
  logic       busy;
  logic       cache_wr;
  assign op = wdata_in[`CCD_OP_HI:`CCD_OP_LO];
  assign busy = (r_r.state != CCD_IDLE);
  assign cache_wr = cmd_wr_in | air_wr_in;

  always_comb begin
    r_nxt = r_r;
    r_nxt.load = 1'b0;
    if (stat_rd_in) begin
      r_nxt.aborted = 1'b0;
    end
    if (busy && cache_wr && !r_r.stall_mode) begin
      r_nxt.aborted = 1'b1;
    end else if (air_wr_in) begin
      r_nxt.air = wdata_in;
    end else if (cmd_wr_in) begin
      r_nxt.cmd = wdata_in;
      case (op)
        `CCD_OP_REFRESH: begin
          if (wdata_in[25:14] == 12'h000) begin
            r_nxt.cfg.refresh = wdata_in[`CCD_RATE_HI:0];
          end
        end
        `CCD_OP_EN: begin
          if (rest_zero(wdata_in, 5'd25)) r_nxt.cfg.cache_en = 1'b1;
        end
        `CCD_OP_DIS: begin
          if (rest_zero(wdata_in, 5'd25)) r_nxt.cfg.cache_en = 1'b0;
        end
        `CCD_OP_SLOCK: begin
          if (rest_zero(wdata_in, 5'd25)) r_nxt.cfg.lock_on = 1'b1;
        end
        `CCD_OP_ELOCK: begin
          if (rest_zero(wdata_in, 5'd25)) r_nxt.cfg.lock_on = 1'b0;
        end
        `CCD_OP_SETBUS: begin
          if (rest_zero(wdata_in, 5'd14) && wdata_in[25:22] == 4'h0) begin
            r_nxt.cfg.i_cache = wdata_in[`CCD_I_BIT];
            r_nxt.cfg.s_cache = wdata_in[`CCD_S_HI -: 2];
            r_nxt.cfg.j_cache = wdata_in[`CCD_J_HI -: 2];
            r_nxt.cfg.k_cache = wdata_in[`CCD_K_HI -: 2];
          end
        end
        `CCD_OP_FILL, `CCD_OP_FILL_LOCK, `CCD_OP_CB, `CCD_OP_INV: begin
          if (!busy && wdata_in[25:24] == 2'h0 && rest_zero(wdata_in, 5'd13)) begin
            r_nxt.state = CCD_RUN;
            r_nxt.remain = wdata_in[`CCD_LEN_HI:`CCD_LEN_LO];
            r_nxt.stall_mode = wdata_in[`CCD_STALL_BIT];
            r_nxt.step.valid = 1'b1;
            r_nxt.step.lock = (op == `CCD_OP_FILL_LOCK);
            r_nxt.step.length = wdata_in[`CCD_LEN_HI:`CCD_LEN_LO];
            r_nxt.step.kind = (op == `CCD_OP_CB) ? CCD_K_CB :
                              (op == `CCD_OP_INV) ? CCD_K_INV : CCD_K_FILL;
            r_nxt.step.use_index = (op == `CCD_OP_CB) || (op == `CCD_OP_INV);
            r_nxt.step.addr = r_r.air[`CCD_ADDR_HI:`CCD_ADDR_LO];
            r_nxt.step.index = r_r.air[`CCD_ADDR_HI:`CCD_IDX_LO];
            r_nxt.load = 1'b1;
          end
        end
        default: begin
          r_nxt.cmd = r_r.cmd;
        end
      endcase
    end
    r_nxt.step_req = 1'b0;
    r_nxt.fetch_grant = fetch_req_in;
    case (r_r.state)
      CCD_IDLE: begin
        r_nxt.core_stall = 1'b0;
      end
      CCD_RUN: begin
        r_nxt.core_stall = r_r.stall_mode;
        if (r_r.remain == 9'h000) begin
          r_nxt.state = CCD_DONE;
        end else if (!core_req_in) begin
          if (fetch_req_in && r_r.turn) begin
            r_nxt.fetch_grant = 1'b1;
            r_nxt.turn = 1'b0;
          end else begin
            r_nxt.fetch_grant = 1'b0;
            r_nxt.step_req = 1'b1;
            r_nxt.turn = 1'b1;
            r_nxt.state = CCD_WAIT;
          end
        end
      end
      CCD_WAIT: begin
        r_nxt.step_req = 1'b1;
        if (step_ack_in) begin
          r_nxt.step_req = 1'b0;
          r_nxt.remain = r_r.remain - 9'h001;
          r_nxt.step.addr = r_r.step.addr + 14'h0001;
          r_nxt.step.index = r_r.step.index + 7'h01;
          r_nxt.load = 1'b1;
          r_nxt.state = CCD_RUN;
        end else if (core_req_in) begin
          r_nxt.step_req = 1'b0;
          r_nxt.state = CCD_RUN;
        end
      end
      CCD_DONE: begin
        r_nxt.step.valid = 1'b0;
        r_nxt.load = 1'b1;
        r_nxt.core_stall = 1'b0;
        r_nxt.state = CCD_IDLE;
      end
      default: begin
        r_nxt.state = CCD_IDLE;
      end
    endcase
    r_nxt.wr_last = cache_wr;
    if (blk_rd_in && r_r.wr_last && r_r.rd_cnt == 3'h0) begin
      r_nxt.rd_cnt = `CCD_READ_STALL;
    end else if (r_r.rd_cnt != 3'h0) begin
      r_nxt.rd_cnt = r_r.rd_cnt - 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_r <= '0;
      r_r.state <= CCD_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  ccd_step_reg u_step (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .load_in  (r_nxt.load),
    .step_in  (r_nxt.step),
    .step_out (step_q)
  );

  always_comb begin
    cmd_word_out = r_r.cmd;
    air_word_out = r_r.air;
    status_out = `CCD_STATUS_RESET;
    status_out[21] = r_r.cfg.i_cache;
    status_out[20:19] = r_r.cfg.s_cache;
    status_out[18:17] = r_r.cfg.j_cache;
    status_out[16:15] = r_r.cfg.k_cache;
    status_out[14] = r_r.stall_mode & busy;
    status_out[31] = busy;
    status_out[30] = r_r.aborted;
    status_out[0] = r_r.cfg.cache_en;
    status_out[2] = r_r.cfg.lock_on;
    cfg_out = r_r.cfg;
    step_out = step_q;
    step_req_out = r_r.step_req;
    fetch_grant_out = r_r.fetch_grant;
    core_stall_out = r_r.core_stall;
    rd_stall_out = (r_r.rd_cnt != 3'h0);
  end
endmodule

// [common/ccd_params.svh]
// constants of the cache memory command decoder
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH
`define CCD_OP_EN        6'h00
`define CCD_OP_DIS       6'h01
`define CCD_OP_SLOCK     6'h02
`define CCD_OP_ELOCK     6'h03
`define CCD_OP_CB        6'h04
`define CCD_OP_INV       6'h05
`define CCD_OP_SETBUS    6'h07
`define CCD_OP_FILL      6'h10
`define CCD_OP_FILL_LOCK 6'h11
`define CCD_OP_REFRESH   6'h14
`define CCD_OP_HI        31
`define CCD_OP_LO        26
`define CCD_LEN_HI       23
`define CCD_LEN_LO       15
`define CCD_STALL_BIT    14
`define CCD_RATE_HI      13
`define CCD_I_BIT        21
`define CCD_S_HI         20
`define CCD_J_HI         18
`define CCD_K_HI         16
`define CCD_ADDR_HI      16
`define CCD_ADDR_LO      3
`define CCD_IDX_LO       10
`define CCD_READ_STALL   3'h4
`define CCD_STATUS_RESET 32'h000001C2
`endif

// [common/ccd_pkg.sv]
// types of the cache memory command decoder
package ccd_pkg;
  typedef enum logic [3:0] {
    CCD_IDLE = 4'b0001,
    CCD_RUN  = 4'b0010,
    CCD_WAIT = 4'b0100,
    CCD_DONE = 4'b1000
  } ccd_state_type;

  typedef enum logic [1:0] {
    CCD_K_FILL = 2'h0,
    CCD_K_CB   = 2'h1,
    CCD_K_INV  = 2'h2
  } ccd_kind_type;

  typedef struct packed {
    logic       valid;
    logic [1:0] kind;
    logic       lock;
    logic       use_index;
    logic [13:0] addr;
    logic [6:0] index;
    logic [8:0] length;
  } ccd_step_type;

  typedef struct packed {
    logic       cache_en;
    logic       lock_on;
    logic       i_cache;
    logic [1:0] s_cache;
    logic [1:0] j_cache;
    logic [1:0] k_cache;
    logic [13:0] refresh;
  } ccd_cfg_type;
endpackage

// [rtl/ccd_step_reg.sv]
// output register stage holding the current background step
`timescale 1ns/1ps
module ccd_step_reg
  import ccd_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         load_in,
  input  ccd_step_type      step_in,
  output ccd_step_type      step_out
);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      step_out <= '0;
    end else if (load_in) begin
      step_out <= step_in;
    end
  end
endmodule

// [verif/ccd_decoder_assertions.sv]
// port assertions of the cache command decoder
`timescale 1ns/1ps
`include "ccd_params.svh"
module ccd_chk
  import ccd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        cmd_wr_in,
  input  wire logic        air_wr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        blk_rd_in,
  input  wire logic [31:0] status_out,
  input  ccd_cfg_type      cfg_out,
  input  ccd_step_type     step_out,
  input  wire logic        rd_stall_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic cw;
  assign cw = cmd_wr_in && !air_wr_in && !status_out[31];
  chk_reset_value: assert property (disable iff (1'b0)
    rst_in |=> status_out == `CCD_STATUS_RESET && cfg_out == '0) else $error("bad reset");
  chk_enable_cmd: assert property (cw && wdata_in == 32'h0 |=> cfg_out.cache_en)
    else $error("enable lost");
  chk_disable_cmd: assert property (cw && wdata_in == 32'h0400_0000 |=> !cfg_out.cache_en)
    else $error("disable lost");
  chk_lock_begin: assert property (cw && wdata_in == 32'h0800_0000 |=> cfg_out.lock_on)
    else $error("lock lost");
  chk_refresh_load: assert property (cw && wdata_in[31:14] == 18'h14000
    |=> cfg_out.refresh == $past(wdata_in[13:0])) else $error("refresh wrong");
  chk_bus_fields: assert property (cw && wdata_in[31:22] == 10'h070
    && wdata_in[14:0] == 15'h0 |=> {cfg_out.i_cache, cfg_out.s_cache, cfg_out.j_cache,
    cfg_out.k_cache} == $past(wdata_in[21:15])) else $error("bus setting wrong");
  chk_undef_ignored: assert property (cw && wdata_in[31:26] == 6'h3F
    |=> $stable(cfg_out)) else $error("undefined opcode acted");
  chk_long_running: assert property (cw && wdata_in[31:26] == 6'h10
    && wdata_in[25:24] == 2'h0 && wdata_in[13:0] == 14'h0 && wdata_in[23:15] != 9'h0
    |=> status_out[31] && step_out.valid) else $error("fill not started");
  chk_abort_set: assert property (status_out[31] && !status_out[14]
    && (cmd_wr_in || air_wr_in) |=> status_out[30]) else $error("abort not flagged");
  chk_read_stall: assert property (blk_rd_in && $past(cmd_wr_in || air_wr_in)
    |=> rd_stall_out [*4] ##1 !rd_stall_out) else $error("read stall length");
  cover property (cw && wdata_in[31:26] == 6'h10);
  cover property (status_out[30]);
  cover property (rd_stall_out);
endmodule
bind ccd_decoder ccd_chk u_chk (.clk_in, .rst_in, .cmd_wr_in, .air_wr_in, .wdata_in,
  .blk_rd_in, .status_out, .cfg_out, .step_out, .rd_stall_out);

// [verif/ccd_mem_model.sv]
// step responder standing for the cache array
`timescale 1ns/1ps
module ccd_mem_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       step_req_in,
  input  wire logic [3:0] delay_in,
  output logic            step_ack_out
);
  logic [3:0] wait_r;
  always_ff @(posedge clk_in) begin
    if (rst_in || step_ack_out || !step_req_in) begin
      wait_r       <= 4'h0;
      step_ack_out <= 1'b0;
    end else if (wait_r == delay_in) begin
      step_ack_out <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// [verif/tb.sv]
// self-checking bench of the cache command decoder
`timescale 1ns/1ps
`include "ccd_params.svh"
module tb;
  import ccd_pkg::*;
  logic         clk_in = 0, rst_in = 1, cmd_wr_in = 0, air_wr_in = 0, stat_rd_in = 0;
  logic         blk_rd_in = 0, core_req_in = 0, fetch_req_in = 0, step_ack_in;
  logic [31:0]  wdata_in = '0, cmd_word_out, air_word_out, status_out;
  logic [3:0]   delay = 4'h2;
  logic [6:0]   f;
  ccd_cfg_type  cfg_out;
  ccd_step_type step_out;
  logic         step_req_out, fetch_grant_out, core_stall_out, rd_stall_out;
  int           fails = 0, tests_run = 0, n, grants = 0;
  ccd_decoder DUT (.*);
  ccd_mem_model u_mem (.clk_in, .rst_in, .step_req_in(step_req_out), .delay_in(delay),
    .step_ack_out(step_ack_in));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) grants += fetch_grant_out;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic air, input logic [31:0] d);
    @(negedge clk_in);
    {air_wr_in, cmd_wr_in} = {air, !air};
    wdata_in = d;
    @(negedge clk_in);
    {air_wr_in, cmd_wr_in} = 2'b00;
  endtask
  task automatic idle_wait();
    n = 0;
    while (status_out[31] !== 1'b0 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    check(32'(n < 200), 32'h1);
  endtask
  task automatic conclude();
    $display("mismatches %0d of %0d checks", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    repeat (16) @(negedge clk_in);
    rst_in = 0;
    check(status_out, `CCD_STATUS_RESET);
    wr(0, 32'h0000_0000);
    check(cfg_out.cache_en, 1);
    wr(0, 32'h0400_0000);
    check(cfg_out.cache_en, 0);
    wr(0, 32'h0800_0000);
    check(cfg_out.lock_on, 1);
    wr(0, 32'h0C00_0000);
    check(cfg_out.lock_on, 0);
    wr(0, 32'h5000_3ABC);
    wr(0, 32'h5000_7001);
    check(cfg_out.refresh, 14'h3ABC);
    wr(0, 32'hFC00_0000);
    check(32'(cfg_out), 32'h3ABC);
    for (int i = 0; i < 4; i++) begin
      f = {i[0], {3{i[1:0]}}};
      wr(0, 32'h1C00_0000 | 32'({f, 15'h0}));
      check(status_out[21:15], f);
      check({cfg_out.i_cache, cfg_out.s_cache, cfg_out.j_cache, cfg_out.k_cache}, f);
    end
    wr(1, 32'h0001_2345);
    fetch_req_in = 1;
    wr(0, 32'h4001_4000);
    check({status_out[31], status_out[14], step_out.valid}, 3'h7);
    check({step_out.kind, step_out.addr, step_out.length}, {2'h0, 14'h2468, 9'h2});
    check(cmd_word_out, 32'h4001_4000);
    core_req_in = 1;
    repeat (3) @(negedge clk_in);
    check({step_req_out, core_stall_out, status_out[31]}, 3'h3);
    core_req_in = 0;
    idle_wait();
    check(32'(grants > 0), 32'h1);
    check(step_out.valid, 0);
    wr(0, 32'h4400_0000);
    check({step_out.valid, step_out.lock}, 2'h3);
    idle_wait();
    fetch_req_in = 0;
    delay = 4'h8;
    for (int k = 0; k < 2; k++) begin
      wr(0, 32'h1000_8000 | (32'(k) << 26));
      check({step_out.kind, step_out.use_index, step_out.index}, {k[1:0] + 2'h1, 8'hC8});
      wr(1, 32'h0);
      check({status_out[30], air_word_out}, {1'b1, 32'h0001_2345});
      idle_wait();
      @(negedge clk_in);
      stat_rd_in = 1;
      @(negedge clk_in);
      stat_rd_in = 0;
      check(status_out[30], 0);
    end
    cmd_wr_in = 1;
    @(negedge clk_in);
    cmd_wr_in = 0;
    blk_rd_in = 1;
    @(negedge clk_in);
    blk_rd_in = 0;
    n = 0;
    repeat (8) begin
      n += rd_stall_out;
      @(negedge clk_in);
    end
    check(32'(n), 32'h4);
    conclude();
  end
endmodule
